// ===== hw/ddc_regs.svh
// Register offsets, field positions, reset values and page codes for the dual converter control
//Contract
// [R1] Control bits 2:0 select data format
// [R2] Format 000: high[3:0], whole low byte
// [R3] Format 001: high[4:0], low[7:1]
// [R4] Format 010: high[5:0], low[7:2]
// [R5] Format 011: high[6:0], low[7:3]
// [R6] Format 1xx: whole high, low[7:4]
// [R7] Control bit 7 enables channel output
// [R8] Mode 00 updates on high byte write
// [R9] Modes 01/10/11 use timers 3/4/2
// [R10] Control bits 6:5 read zero, ignored
// [R11] Data bytes fully readable and writable
// [R12] Second identical channel on page one
// [R13] Low write held until high write
// [R14] Timer modes latch only on overflow
// [R15] Software writes low before high byte
// [R16] Reset clears all registers of both
// [R17] Unused data bits stored, ignored
`ifndef DDC_REGS_SVH
`define DDC_REGS_SVH
`define DDC_OFS_DATA_LOW 8'hD2
`define DDC_OFS_DATA_HIGH 8'hD3
`define DDC_OFS_CONTROL 8'hD4
`define DDC_PAGE_CHAN0 8'h00
`define DDC_PAGE_CHAN1 8'h01
`define DDC_CTL_EN_BIT 7
`define DDC_CTL_MODE_HI 4
`define DDC_CTL_MODE_LO 3
`define DDC_CTL_FMT_HI 2
`define DDC_CTL_FMT_LO 0
`define DDC_CTL_WMASK 8'h9F
`define DDC_RESET_BYTE 8'h00
`define DDC_RESET_WORD 12'h000
`endif

// ===== hw/ddc_pkg.sv
// Types shared by the dual converter control files
package ddc_pkg;
    // Update trigger codes held in control bits 4:3
    typedef enum logic [1:0] {
        DDC_UPD_WRITE = 2'h0,
        DDC_UPD_TMR3 = 2'h1,
        DDC_UPD_TMR4 = 2'h2,
        DDC_UPD_TMR2 = 2'h3
    } ddc_update_type;
endpackage

// ===== hw/ddc_channel.sv
// One converter channel: data and control registers, format unpacking and output latch
`timescale 1ns/1ps
`default_nettype none
`include "ddc_regs.svh"
module ddc_channel
    import ddc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register writes for this channel
    input wire logic i_wr_low,
    input wire logic i_wr_high,
    input wire logic i_wr_ctl,
    input wire logic [7:0] i_wdata,
    // Timer overflow pulses
    input wire logic i_tmr2_ovf,
    input wire logic i_tmr3_ovf,
    input wire logic i_tmr4_ovf,
    // Register contents
    output logic [7:0] o_data_low,
    output logic [7:0] o_data_high,
    output logic [7:0] o_control,
    // Converter side
    output logic [11:0] o_word,
    output logic o_enable
);
    logic [7:0] low_r; // Stored as written, all bits kept
    logic [7:0] high_r;
    logic [7:0] ctl_r; // Bits 6:5 never set
    logic [11:0] word_r; // Converter input latch
    logic en_r;
    wire [2:0] fmt = ctl_r[`DDC_CTL_FMT_HI:`DDC_CTL_FMT_LO]; // [R1]
    wire ddc_update_type mode = ddc_update_type'(ctl_r[`DDC_CTL_MODE_HI:`DDC_CTL_MODE_LO]);
    logic [11:0] fmt_word;
    logic upd;

    // Alignment decode; bits outside the field are dropped
    always_comb begin
        fmt_word = {high_r[3:0], low_r}; // [R2] [R17]
        if (fmt[2]) begin
            fmt_word = {high_r, low_r[7:4]}; // [R6]
        end else if (fmt == 3'h1) begin
            fmt_word = {high_r[4:0], low_r[7:1]}; // [R3]
        end else if (fmt == 3'h2) begin
            fmt_word = {high_r[5:0], low_r[7:2]}; // [R4]
        end else if (fmt == 3'h3) begin
            fmt_word = {high_r[6:0], low_r[7:3]}; // [R5]
        end
    end

    // Trigger select; a high byte write counts only in mode 00
    always_comb begin
        unique case (mode)
            DDC_UPD_WRITE: upd = i_wr_high; // [R8] [R13]
            DDC_UPD_TMR3: upd = i_tmr3_ovf; // [R9] [R14]
            DDC_UPD_TMR4: upd = i_tmr4_ovf; // [R9]
            DDC_UPD_TMR2: upd = i_tmr2_ovf; // [R9]
        endcase
    end

    // Register stores
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            low_r <= `DDC_RESET_BYTE; // [R16]
            high_r <= `DDC_RESET_BYTE;
            ctl_r <= `DDC_RESET_BYTE;
        end else begin
            if (i_wr_low) low_r <= i_wdata; // [R11]
            if (i_wr_high) high_r <= i_wdata;
            if (i_wr_ctl) ctl_r <= i_wdata & `DDC_CTL_WMASK; // [R10]
        end
    end

    // Output latch; in write mode the word is formed one cycle after the high write
    logic upd_d;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            upd_d <= 1'b0;
            word_r <= `DDC_RESET_WORD;
            en_r <= 1'b0;
        end else begin
            upd_d <= upd;
            if (upd_d) word_r <= fmt_word; // [R13] [R14]
            en_r <= ctl_r[`DDC_CTL_EN_BIT]; // [R7]
        end
    end

    assign o_data_low = low_r;
    assign o_data_high = high_r;
    assign o_control = ctl_r;
    assign o_word = word_r;
    assign o_enable = en_r;

    // Word must follow its trigger by two cycles when data was stable
    property p_latch;
        @(posedge i_clk) disable iff (i_rst)
        (upd && !i_wr_low && !i_wr_high && !i_wr_ctl) |=> ##1 (word_r == $past(fmt_word));
    endproperty
    a_latch: assert property (p_latch) else $error("latch missed trigger"); // [R14]

    property p_hold;
        @(posedge i_clk) disable iff (i_rst)
        !upd_d |=> $stable(word_r);
    endproperty
    a_hold: assert property (p_hold) else $error("word changed without trigger"); // [R13]

    property p_unused;
        @(posedge i_clk) disable iff (i_rst)
        ctl_r[6:5] == 2'h0;
    endproperty
    a_unused: assert property (p_unused) else $error("unused control bits set"); // [R10]

    property p_enable;
        @(posedge i_clk) disable iff (i_rst)
        i_wr_ctl |=> ##1 (en_r == $past(i_wdata[7], 2));
    endproperty
    a_enable: assert property (p_enable) else $error("enable not following control"); // [R7]

    property p_store;
        @(posedge i_clk) disable iff (i_rst)
        i_wr_low |=> (low_r == $past(i_wdata));
    endproperty
    a_store: assert property (p_store) else $error("low byte not stored"); // [R11]

    property p_fmt8;
        @(posedge i_clk) disable iff (i_rst)
        fmt[2] |-> (fmt_word == {high_r, low_r[7:4]});
    endproperty
    a_fmt8: assert property (p_fmt8) else $error("format 1xx wrong"); // [R6]

    property p_fmt0;
        @(posedge i_clk) disable iff (i_rst)
        (fmt == 3'h0) |-> (fmt_word[11:8] == high_r[3:0]);
    endproperty
    a_fmt0: assert property (p_fmt0) else $error("format 000 wrong"); // [R2]

    property p_wmode;
        @(posedge i_clk) disable iff (i_rst)
        (mode == DDC_UPD_WRITE && (i_tmr2_ovf || i_tmr3_ovf || i_tmr4_ovf) && !i_wr_high) |-> !upd;
    endproperty
    a_wmode: assert property (p_wmode) else $error("timer fired in write mode"); // [R8]
endmodule
`default_nettype wire

// ===== hw/ddc_top.sv
// Dual converter control: register page decode, read mux and two channels
`timescale 1ns/1ps
`default_nettype none
`include "ddc_regs.svh"
module ddc_top
    import ddc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Special function register access
    input wire logic [7:0] i_sfr_addr,
    input wire logic [7:0] i_sfr_page,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    output logic o_sfr_hit,
    // Timer overflow pulses
    input wire logic i_tmr2_ovf,
    input wire logic i_tmr3_ovf,
    input wire logic i_tmr4_ovf,
    // Converter inputs
    output logic [11:0] o_chan0_word,
    output logic o_chan0_enable,
    output logic [11:0] o_chan1_word,
    output logic o_chan1_enable
);
    // Page decode keeps the two channels apart at one offset set
    wire pg0 = (i_sfr_page == `DDC_PAGE_CHAN0);
    wire pg1 = (i_sfr_page == `DDC_PAGE_CHAN1); // [R12]
    wire a_lo = (i_sfr_addr == `DDC_OFS_DATA_LOW);
    wire a_hi = (i_sfr_addr == `DDC_OFS_DATA_HIGH);
    wire a_ct = (i_sfr_addr == `DDC_OFS_CONTROL);
    wire hit = (pg0 || pg1) && (a_lo || a_hi || a_ct);
    logic [7:0] l0, h0, c0, l1, h1, c1;
    logic [7:0] rdata_r;
    logic hit_r;

    ddc_channel u_ch0 (
        .i_clk(i_clk), .i_rst(i_rst),
        .i_wr_low(i_sfr_wr && pg0 && a_lo), .i_wr_high(i_sfr_wr && pg0 && a_hi),
        .i_wr_ctl(i_sfr_wr && pg0 && a_ct), .i_wdata(i_sfr_wdata),
        .i_tmr2_ovf(i_tmr2_ovf), .i_tmr3_ovf(i_tmr3_ovf), .i_tmr4_ovf(i_tmr4_ovf),
        .o_data_low(l0), .o_data_high(h0), .o_control(c0),
        .o_word(o_chan0_word), .o_enable(o_chan0_enable)
    );
    ddc_channel u_ch1 (
        .i_clk(i_clk), .i_rst(i_rst),
        .i_wr_low(i_sfr_wr && pg1 && a_lo), .i_wr_high(i_sfr_wr && pg1 && a_hi),
        .i_wr_ctl(i_sfr_wr && pg1 && a_ct), .i_wdata(i_sfr_wdata),
        .i_tmr2_ovf(i_tmr2_ovf), .i_tmr3_ovf(i_tmr3_ovf), .i_tmr4_ovf(i_tmr4_ovf),
        .o_data_low(l1), .o_data_high(h1), .o_control(c1),
        .o_word(o_chan1_word), .o_enable(o_chan1_enable)
    );

    // Read mux; unmapped addresses read zero
    wire [7:0] rd0 = a_lo ? l0 : a_hi ? h0 : a_ct ? c0 : 8'h00;
    wire [7:0] rd1 = a_lo ? l1 : a_hi ? h1 : a_ct ? c1 : 8'h00;
    wire [7:0] rd = pg0 ? rd0 : pg1 ? rd1 : 8'h00;

    // Registered read data, valid the cycle after the strobe
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            rdata_r <= `DDC_RESET_BYTE;
            hit_r <= 1'b0;
        end else begin
            rdata_r <= i_sfr_rd ? rd : 8'h00;
            hit_r <= i_sfr_rd && hit;
        end
    end
    assign o_sfr_rdata = rdata_r;
    assign o_sfr_hit = hit_r;
endmodule
`default_nettype wire

// ===== verif/ddc_cpu_model.sv
// Processor-side register bus model for the converter control
`timescale 1ns/1ps
`default_nettype none
module ddc_cpu_model (
    // Clock
    input wire logic i_clk,
    // Register bus to the block
    output logic [7:0] o_addr,
    output logic [7:0] o_page,
    output logic o_wr,
    output logic o_rd,
    output logic [7:0] o_wdata,
    input wire logic [7:0] i_rdata,
    input wire logic i_hit
);
    // Quiet bus at time zero
    initial begin
        {o_addr, o_page, o_wr, o_rd, o_wdata} = '0;
    end
    // One-cycle write; data inverted after so a stale byte never counts
    task automatic wr(input logic [7:0] pg, ad, dt);
        @(posedge i_clk);
        {o_page, o_addr, o_wdata, o_wr} <= {pg, ad, dt, 1'b1};
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_wdata <= ~dt;
    endtask
    // One-cycle read; answer taken once the sampling edge has landed
    task automatic rd(input logic [7:0] pg, ad, output logic [7:0] dt, output logic ht);
        @(posedge i_clk);
        {o_page, o_addr, o_rd} <= {pg, ad, 1'b1};
        @(posedge i_clk);
        o_rd <= 1'b0;
        #1;
        dt = i_rdata;
        ht = i_hit;
    endtask
endmodule
`default_nettype wire

// ===== verif/dual_dac_update_format_ctrl_test.sv
// Self-checking bench for the dual converter control
`timescale 1ns/1ps
`default_nettype none
`include "ddc_regs.svh"
module dual_dac_update_format_ctrl_test;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr, page, wdata, rdata, d;
    logic wr, rd, hit, h, e0, e1;
    logic [2:0] tmr = 3'h0; // Bit0 timer 2, bit1 timer 3, bit2 timer 4
    logic [11:0] w0, w1;
    int fails = 0;
    int tests_run = 0;
    // Expected words per format code from high 5A and low C3
    logic [11:0] fmt_word [8] = '{12'hAC3, 12'hD61, 12'h6B0, 12'hB58, 12'h5AC, 12'h5AC, 12'h5AC, 12'h5AC};
    always #2.5 clk = ~clk;
    ddc_top u_dut (.i_clk(clk), .i_rst(rst), .i_sfr_addr(addr), .i_sfr_page(page), .i_sfr_wr(wr),
        .i_sfr_rd(rd), .i_sfr_wdata(wdata), .o_sfr_rdata(rdata), .o_sfr_hit(hit), .i_tmr2_ovf(tmr[0]),
        .i_tmr3_ovf(tmr[1]), .i_tmr4_ovf(tmr[2]), .o_chan0_word(w0), .o_chan0_enable(e0),
        .o_chan1_word(w1), .o_chan1_enable(e1));
    ddc_cpu_model u_cpu (.i_clk(clk), .o_addr(addr), .o_page(page), .o_wr(wr), .o_rd(rd),
        .o_wdata(wdata), .i_rdata(rdata), .i_hit(hit));
    // Compare and count
    task automatic chk(input logic [11:0] got, exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Read a byte and expect a mapped hit
    task automatic rdchk(input logic [7:0] pg, ad, exp);
        u_cpu.rd(pg, ad, d, h);
        chk({4'h0, d}, {4'h0, exp});
        chk({11'h0, h}, 12'h1);
    endtask
    // Let a trigger reach the converter latch
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // Row loop: every format on both channels, unused control bits written as ones
        for (int c = 0; c < 2; c++) begin
            for (int f = 0; f < 8; f++) begin
                u_cpu.wr(8'(c), `DDC_OFS_CONTROL, 8'(8'hE0 | f));
                u_cpu.wr(8'(c), `DDC_OFS_DATA_LOW, 8'hC3);
                u_cpu.wr(8'(c), `DDC_OFS_DATA_HIGH, 8'h5A);
                settle();
                chk(c ? w1 : w0, fmt_word[f]);
                chk({11'h0, c ? e1 : e0}, 12'h1);
                rdchk(8'(c), `DDC_OFS_CONTROL, 8'(8'h80 | f));
                rdchk(8'(c), `DDC_OFS_DATA_LOW, 8'hC3);
                rdchk(8'(c), `DDC_OFS_DATA_HIGH, 8'h5A);
            end
        end
        $display("Format rows done");
        // Low byte and timers alone must not move a write-triggered word
        u_cpu.wr(8'h00, `DDC_OFS_CONTROL, 8'h80);
        u_cpu.wr(8'h00, `DDC_OFS_DATA_LOW, 8'h11);
        @(posedge clk) tmr <= 3'h7;
        @(posedge clk) tmr <= 3'h0;
        settle();
        chk(w0, 12'h5AC);
        u_cpu.wr(8'h00, `DDC_OFS_DATA_HIGH, 8'h02);
        settle();
        chk(w0, 12'h211);
        // Each timer mode fires only on its own overflow
        for (int m = 1; m < 4; m++) begin
            u_cpu.wr(8'h01, `DDC_OFS_CONTROL, 8'(8'h80 | (m << 3)));
            u_cpu.wr(8'h01, `DDC_OFS_DATA_LOW, 8'h00);
            u_cpu.wr(8'h01, `DDC_OFS_DATA_HIGH, 8'(m));
            @(posedge clk) tmr <= 3'h7 & ~(3'h1 << (m % 3));
            @(posedge clk) tmr <= 3'h0;
            settle();
            chk(w1, (m == 1) ? 12'h5AC : 12'((m - 1) << 8));
            @(posedge clk) tmr <= 3'h1 << (m % 3);
            @(posedge clk) tmr <= 3'h0;
            settle();
            chk(w1, 12'(m << 8));
        end
        $display("Update triggers done");
        // Unmapped places read zero without a hit, and writes there are lost
        u_cpu.wr(8'h02, `DDC_OFS_CONTROL, 8'hFF);
        u_cpu.rd(8'h00, 8'hD5, d, h);
        chk({3'h0, d, h}, 12'h0);
        u_cpu.rd(8'h02, `DDC_OFS_CONTROL, d, h);
        chk({3'h0, d, h}, 12'h0);
        rdchk(8'h00, `DDC_OFS_CONTROL, 8'h80);
        u_cpu.wr(8'h00, `DDC_OFS_CONTROL, 8'h00);
        settle();
        chk({11'h0, e0}, 12'h0);
        $display("Register map done");
        // Reset in mid-run clears both channels
        @(posedge clk) rst <= 1'b1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk(w0 | w1 | {e0, e1}, 12'h0);
        for (int a = 0; a < 6; a++) begin
            rdchk(8'(a / 3), 8'(`DDC_OFS_DATA_LOW + a % 3), 8'h00);
        end
        $display("Reset done");
        stop_test();
    end
    // Watchdog well beyond the few hundred cycles of the sequence
    initial begin
        #100000;
        fails++;
        stop_test();
    end
endmodule
`default_nettype wire
